/* rtl/ucrm_consts.vh */
// Register offsets, field positions and reset values of the channel register map
`ifndef UCRM_CONSTS_VH
`define UCRM_CONSTS_VH
`define UCRM_OFS_HOLDING 4'h0
`define UCRM_OFS_INT_EN 4'h1
`define UCRM_OFS_INT_STAT 4'h2
`define UCRM_OFS_LINE_CTL 4'h3
`define UCRM_OFS_MODEM_CTL 4'h4
`define UCRM_OFS_LINE_STAT 4'h5
`define UCRM_OFS_MODEM_STAT 4'h6
`define UCRM_OFS_SCRATCH 4'h7
`define UCRM_OFS_FEATURE 4'h8
`define UCRM_OFS_ENHANCED 4'h9
`define UCRM_OFS_TX_LEVEL 4'ha
`define UCRM_OFS_RX_LEVEL 4'hb
`define UCRM_OFS_FLOW_FLAGS 4'hc
`define UCRM_OFS_PAUSE2 4'hd
`define UCRM_OFS_RESUME1 4'he
`define UCRM_OFS_RESUME2 4'hf
`define UCRM_LINE_CTL_DIV_BIT 7
`define UCRM_ENH_FN_EN_BIT 4
`define UCRM_MODEM_CTL_LOOP_BIT 4
`define UCRM_INT_EN_ENH_MASK 8'he0
`define UCRM_INT_EN_WR_MASK 8'hef
`define UCRM_INT_STAT_ENH_MASK 8'h30
`define UCRM_FIFO_CTL_ENH_MASK 8'h30
`define UCRM_MODEM_CTL_ENH_MASK 8'he4
`define UCRM_DELAY_ENH_MASK 4'hf
`define UCRM_RST_BYTE 8'h00
`define UCRM_RST_DIVISOR 16'h0000
`define UCRM_RST_NIBBLE 4'h0
`define UCRM_RST_FLAGS 2'b00
`define UCRM_SYNC_IDLE 3'h7
`endif

/* rtl/ucrm_char_store.v */
// Small register memory for the flow-control characters
`timescale 1ns/1ps
module ucrm_char_store (
  input wire clk_i,
  input wire resetn_i,
  input wire we_i,
  input wire [1:0] waddr_i,
  input wire [7:0] wdata_i,
  input wire [1:0] raddr_i,
  output reg [7:0] rdata_o
);
  reg [7:0] mem [0:3];
  integer k;

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (k = 0; k < 4; k = k + 1) begin
        mem[k] <= 8'h00;
      end
      rdata_o <= 8'h00;
    end else begin
      if (we_i) begin
        mem[waddr_i] <= wdata_i;
      end
      rdata_o <= mem[raddr_i];
    end
  end
endmodule

/* rtl/ucrm_channel_regs.v */
// One UART channel register map: decode, storage, enhanced gating, loopback
// Summary of operation
// - Enhanced fields take writes only while enable bit set, keep values until a write made with it clear zeroes them
// - Enable bit gates the listed enhanced control fields
// - Modem-control bits 2 and 3 drive no pins
// - Bits 2 and 3 loop into modem status
// - Four low address bits pick one of sixteen
// - Divisor bytes reachable only with line-control bit 7
// - Loopback turns serial path round, idles outputs
`timescale 1ns/1ps
`include "ucrm_consts.vh"
module ucrm_channel_regs (
  input wire clk_i,
  input wire resetn_i,
  input wire [3:0] addr_i,
  input wire rd_i,
  input wire wr_i,
  input wire [7:0] wdata_i,
  output reg [7:0] rdata_o,
  input wire [7:0] rx_data_i,
  input wire [7:0] line_status_i,
  input wire [3:0] int_source_i,
  input wire [7:0] tx_level_i,
  input wire [7:0] rx_level_i,
  input wire resume_seen_i,
  input wire pause_seen_i,
  input wire tx_serial_i,
  input wire cts_n_i,
  input wire dsr_n_i,
  input wire ri_n_i,
  input wire cd_n_i,
  output wire rx_serial_o,
  output wire tx_pin_o,
  output wire rts_n_o,
  output wire dtr_n_o,
  output reg holding_wr_o,
  output reg holding_rd_o,
  output reg [7:0] transmit_holding_o,
  output reg [7:0] fifo_control_o,
  output reg [15:0] baud_divisor_o,
  output reg [7:0] interrupt_enable_o,
  output reg [7:0] line_control_o,
  output reg [7:0] modem_control_o,
  output reg [7:0] feature_control_o,
  output reg [7:0] enhanced_function_o,
  output reg [7:0] tx_fifo_threshold_o,
  output reg [7:0] rx_fifo_threshold_o,
  output reg [3:0] turnaround_delay_o
);
  reg [7:0] scratch_pad;
  reg [1:0] flow_flags;
  reg [3:0] modem_prev;
  reg [3:0] modem_delta;
  reg [7:0] next_rdata;
  wire enh;
  wire div_sel;
  wire loop;
  wire [3:0] pin_n;
  wire [3:0] pin_stable_n;
  wire [3:0] modem_now;
  wire [3:0] modem_change;
  wire [7:0] modem_status;
  wire [7:0] int_status;
  wire [7:0] int_en_mask;
  wire [7:0] modem_ctl_mask;
  wire [7:0] fifo_ctl_mask;
  wire [3:0] delay_mask;
  wire [1:0] flow_seen;
  wire char_we;
  wire wr_holding;
  wire wr_divisor_low;
  wire wr_divisor_high;
  wire wr_int_en;
  wire wr_fifo_ctl;
  wire wr_line_ctl;
  wire wr_modem_ctl;
  wire wr_delay;
  wire wr_scratch;
  wire wr_feature;
  wire wr_enhanced;
  wire wr_tx_thresh;
  wire wr_rx_thresh;
  wire rd_modem_stat;
  wire rd_flow_flags;
  genvar g;

  assign enh = enhanced_function_o[`UCRM_ENH_FN_EN_BIT];
  assign div_sel = line_control_o[`UCRM_LINE_CTL_DIV_BIT];
  assign loop = modem_control_o[`UCRM_MODEM_CTL_LOOP_BIT];

  // Write strobes, one per register; the divisor bit steers offsets 0 and 1
  assign wr_holding = wr_i && addr_i == `UCRM_OFS_HOLDING && !div_sel;
  assign wr_divisor_low = wr_i && addr_i == `UCRM_OFS_HOLDING && div_sel;
  assign wr_int_en = wr_i && addr_i == `UCRM_OFS_INT_EN && !div_sel;
  assign wr_divisor_high = wr_i && addr_i == `UCRM_OFS_INT_EN && div_sel;
  assign wr_fifo_ctl = wr_i && addr_i == `UCRM_OFS_INT_STAT;
  assign wr_line_ctl = wr_i && addr_i == `UCRM_OFS_LINE_CTL;
  assign wr_modem_ctl = wr_i && addr_i == `UCRM_OFS_MODEM_CTL;
  assign wr_delay = wr_i && addr_i == `UCRM_OFS_MODEM_STAT;
  assign wr_scratch = wr_i && addr_i == `UCRM_OFS_SCRATCH;
  assign wr_feature = wr_i && addr_i == `UCRM_OFS_FEATURE;
  assign wr_enhanced = wr_i && addr_i == `UCRM_OFS_ENHANCED;
  assign wr_tx_thresh = wr_i && addr_i == `UCRM_OFS_TX_LEVEL;
  assign wr_rx_thresh = wr_i && addr_i == `UCRM_OFS_RX_LEVEL;
  // Offsets c to f all land in the character store, which is never read back; c reads the flags, d to f read zero
  assign char_we = wr_i && addr_i[3:2] == 2'b11;
  assign rd_modem_stat = rd_i && addr_i == `UCRM_OFS_MODEM_STAT;
  assign rd_flow_flags = rd_i && addr_i == `UCRM_OFS_FLOW_FLAGS;

  // Enhanced bits are blocked at write time so hidden values never leak later
  assign int_en_mask = enh ? 8'hff : ~`UCRM_INT_EN_ENH_MASK;
  assign modem_ctl_mask = enh ? 8'hff : ~`UCRM_MODEM_CTL_ENH_MASK;
  assign fifo_ctl_mask = enh ? 8'hff : ~`UCRM_FIFO_CTL_ENH_MASK;
  assign delay_mask = enh ? 4'hf : ~`UCRM_DELAY_ENH_MASK;

  // Loopback: serial path turned round, pins parked at idle high
  assign rx_serial_o = loop ? tx_serial_i : 1'b1;
  assign tx_pin_o = loop ? 1'b1 : tx_serial_i;
  assign rts_n_o = loop ? 1'b1 : ~modem_control_o[1];
  assign dtr_n_o = loop ? 1'b1 : ~modem_control_o[0];
  // Bits 2 and 3 feed only the loopback status, there is no pin for them

  // Status order: cd, ri, dsr, cts (active high)
  assign pin_n = {cd_n_i, ri_n_i, dsr_n_i, cts_n_i};
  assign modem_now = loop ?
    {modem_control_o[3], modem_control_o[2], modem_control_o[0], modem_control_o[1]} :
    ~pin_stable_n;
  assign modem_change = modem_now ^ modem_prev;
  assign modem_status = {modem_now, modem_delta};
  assign flow_seen = {resume_seen_i, pause_seen_i};

  // Flow flags show at bits 5:4 only while the enhanced set is on
  assign int_status = {fifo_control_o[0], fifo_control_o[0], flow_flags, int_source_i} &
    (enh ? 8'hff : ~`UCRM_INT_STAT_ENH_MASK);

  ucrm_char_store u_chars (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .we_i(char_we),
    .waddr_i(addr_i[1:0]),
    .wdata_i(wdata_i),
    .raddr_i(addr_i[1:0]),
    .rdata_o()
  );

  // Three stages per pin; a change is taken once the last two agree, so a
  // glitch caught by the first stage never reaches the status bits
  generate
    for (g = 0; g < 4; g = g + 1) begin : pin_sync
      reg [2:0] stage;
      reg stable_n;
      always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          stage <= `UCRM_SYNC_IDLE;
          stable_n <= 1'b1;
        end else begin
          stage <= {stage[1:0], pin_n[g]};
          if (stage[2] == stage[1]) begin
            stable_n <= stage[2];
          end
        end
      end
      assign pin_stable_n[g] = stable_n;
    end
  endgenerate

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      transmit_holding_o <= `UCRM_RST_BYTE;
      holding_wr_o <= 1'b0;
    end else begin
      holding_wr_o <= wr_holding;
      if (wr_holding) begin
        transmit_holding_o <= wdata_i;
      end
    end
  end

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      baud_divisor_o <= `UCRM_RST_DIVISOR;
    end else begin
      if (wr_divisor_low) begin
        baud_divisor_o[7:0] <= wdata_i;
      end
      if (wr_divisor_high) begin
        baud_divisor_o[15:8] <= wdata_i;
      end
    end
  end

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      interrupt_enable_o <= `UCRM_RST_BYTE;
    end else if (wr_int_en) begin
      interrupt_enable_o <= wdata_i & int_en_mask & `UCRM_INT_EN_WR_MASK;
    end
  end

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fifo_control_o <= `UCRM_RST_BYTE;
    end else if (wr_fifo_ctl) begin
      fifo_control_o <= wdata_i & fifo_ctl_mask;
    end
  end

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      line_control_o <= `UCRM_RST_BYTE;
    end else if (wr_line_ctl) begin
      line_control_o <= wdata_i;
    end
  end

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      modem_control_o <= `UCRM_RST_BYTE;
    end else if (wr_modem_ctl) begin
      modem_control_o <= wdata_i & modem_ctl_mask;
    end
  end

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      turnaround_delay_o <= `UCRM_RST_NIBBLE;
    end else if (wr_delay) begin
      turnaround_delay_o <= wdata_i[7:4] & delay_mask;
    end
  end

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      scratch_pad <= `UCRM_RST_BYTE;
    end else if (wr_scratch) begin
      scratch_pad <= wdata_i;
    end
  end

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      feature_control_o <= `UCRM_RST_BYTE;
    end else if (wr_feature) begin
      feature_control_o <= wdata_i;
    end
  end

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      enhanced_function_o <= `UCRM_RST_BYTE;
    end else if (wr_enhanced) begin
      enhanced_function_o <= wdata_i;
    end
  end

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_fifo_threshold_o <= `UCRM_RST_BYTE;
    end else if (wr_tx_thresh) begin
      tx_fifo_threshold_o <= wdata_i;
    end
  end

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_fifo_threshold_o <= `UCRM_RST_BYTE;
    end else if (wr_rx_thresh) begin
      rx_fifo_threshold_o <= wdata_i;
    end
  end

  // Delta and flow flags: a new event in the read cycle survives the clear
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      modem_prev <= `UCRM_RST_NIBBLE;
      modem_delta <= `UCRM_RST_NIBBLE;
      flow_flags <= `UCRM_RST_FLAGS;
    end else begin
      modem_prev <= modem_now;
      if (rd_modem_stat) begin
        modem_delta <= modem_change;
      end else begin
        modem_delta <= modem_delta | modem_change;
      end
      if (rd_flow_flags) begin
        flow_flags <= flow_seen;
      end else begin
        flow_flags <= flow_flags | flow_seen;
      end
    end
  end

  always @* begin
    next_rdata = `UCRM_RST_BYTE;
    case (addr_i)
      `UCRM_OFS_HOLDING: next_rdata = div_sel ? baud_divisor_o[7:0] : rx_data_i;
      `UCRM_OFS_INT_EN: next_rdata = div_sel ? baud_divisor_o[15:8] : interrupt_enable_o;
      `UCRM_OFS_INT_STAT: next_rdata = int_status;
      `UCRM_OFS_LINE_CTL: next_rdata = line_control_o;
      `UCRM_OFS_MODEM_CTL: next_rdata = modem_control_o;
      `UCRM_OFS_LINE_STAT: next_rdata = line_status_i;
      `UCRM_OFS_MODEM_STAT: next_rdata = modem_status;
      `UCRM_OFS_SCRATCH: next_rdata = scratch_pad;
      `UCRM_OFS_FEATURE: next_rdata = feature_control_o;
      `UCRM_OFS_ENHANCED: next_rdata = enhanced_function_o;
      `UCRM_OFS_TX_LEVEL: next_rdata = tx_level_i;
      `UCRM_OFS_RX_LEVEL: next_rdata = rx_level_i;
      `UCRM_OFS_FLOW_FLAGS: next_rdata = {6'h00, flow_flags};
      default: next_rdata = `UCRM_RST_BYTE;
    endcase
  end

  // Read data is latched only on a read, so it stands until the next one
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= `UCRM_RST_BYTE;
      holding_rd_o <= 1'b0;
    end else begin
      holding_rd_o <= rd_i && addr_i == `UCRM_OFS_HOLDING && !div_sel;
      if (rd_i) begin
        rdata_o <= next_rdata;
      end
    end
  end
endmodule

/* testbench/ucrm_checker.sv */
// Concurrent checks on the channel register map ports
`timescale 1ns/1ps
module ucrm_checker (
  input wire clk_i,
  input wire resetn_i,
  input wire [3:0] addr_i,
  input wire wr_i,
  input wire [7:0] wdata_i,
  input wire tx_serial_i,
  input wire rx_serial_o,
  input wire tx_pin_o,
  input wire rts_n_o,
  input wire dtr_n_o,
  input wire holding_wr_o,
  input wire [7:0] transmit_holding_o,
  input wire [7:0] fifo_control_o,
  input wire [3:0] turnaround_delay_o,
  input wire [15:0] baud_divisor_o,
  input wire [7:0] interrupt_enable_o,
  input wire [7:0] line_control_o,
  input wire [7:0] modem_control_o,
  input wire [7:0] enhanced_function_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  wire div = line_control_o[7];
  wire enh = enhanced_function_o[4];
  wire loop = modem_control_o[4];
  sequence wr_at(a);
    wr_i && addr_i == a;
  endsequence
  loop_route_a: assert property (loop |-> rx_serial_o == tx_serial_i)
    else $error("loopback route broken");
  loop_idle_a: assert property (loop |-> tx_pin_o && rts_n_o && dtr_n_o)
    else $error("pins not idle in loopback");
  pin_map_a: assert property (!loop |-> rts_n_o == !modem_control_o[1] &&
    dtr_n_o == !modem_control_o[0] && tx_pin_o == tx_serial_i) else $error("pin map wrong");
  ier_gate_a: assert property (wr_at(4'h1) ##0 !div && !enh |=>
    interrupt_enable_o[7:4] == 4'h0) else $error("gated enable bits stored");
  ier_enh_a: assert property (wr_at(4'h1) ##0 !div && enh |=>
    interrupt_enable_o[7:5] == $past(wdata_i[7:5])) else $error("enhanced bits lost");
  mcr_gate_a: assert property (wr_at(4'h4) ##0 !enh |=>
    (modem_control_o & 8'he4) == 8'h00) else $error("gated modem bits stored");
  fifo_gate_a: assert property (wr_at(4'h2) ##0 !enh |=>
    fifo_control_o[5:4] == 2'b00) else $error("gated fifo bits stored");
  delay_gate_a: assert property (wr_at(4'h6) ##0 !enh |=>
    turnaround_delay_o == 4'h0) else $error("gated delay bits stored");
  div_low_a: assert property (wr_at(4'h0) ##0 div |=>
    baud_divisor_o[7:0] == $past(wdata_i) && !holding_wr_o) else $error("divisor low wrong");
  div_high_a: assert property (wr_at(4'h1) ##0 div |=>
    baud_divisor_o[15:8] == $past(wdata_i) && $stable(interrupt_enable_o))
    else $error("divisor high wrong");
  thr_wr_a: assert property (wr_at(4'h0) ##0 !div |=>
    holding_wr_o && transmit_holding_o == $past(wdata_i)) else $error("holding write wrong");
endmodule

/* testbench/ucrm_host_model.sv */
// Host-side register access driver
`timescale 1ns/1ps
module ucrm_host_model (
  input wire clk_i,
  input wire [7:0] rdata_i,
  output logic [3:0] addr_o,
  output logic rd_o,
  output logic wr_o,
  output logic [7:0] wdata_o
);
  initial begin
    addr_o = 4'h0;
    rd_o = 1'b0;
    wr_o = 1'b0;
    wdata_o = 8'h00;
  end
  // One strobe cycle, then a quiet cycle so a strobe is never re-raised in one step
  task automatic access(input logic w, input logic [3:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    @(posedge clk_i);
    #1;
    addr_o = a;
    wr_o = w;
    rd_o = !w;
    wdata_o = d;
    @(posedge clk_i);
    #1;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = ~d;
    q = rdata_i;
  endtask
endmodule

/* testbench/tb.sv */
// Self-checking bench for the channel register map
`timescale 1ns/1ps
module tb;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [7:0] rx_byte = 8'h5a, line_st = 8'h61, tx_lvl = 8'h07, rx_lvl = 8'h09, q;
  logic [3:0] isrc = 4'h6, addr;
  logic pause = 1'b0, txs = 1'b0, rd, wr;
  logic [7:0] wd, rdata, mctl, thold, fctl, ien, lctl, feat, efn, txth, rxth;
  logic hwr, hrd;
  logic [3:0] dly;
  logic [15:0] baud;
  logic rxs, txp, rts_n, dtr_n;
  int failures = 0;
  int compares = 0;
  always #4 clk_i = ~clk_i;
  ucrm_host_model ucrm_host_model_inst (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr),
    .rd_o(rd), .wr_o(wr), .wdata_o(wd));
  ucrm_channel_regs ucrm_channel_regs_inst (.clk_i(clk_i), .resetn_i(resetn_i),
    .addr_i(addr), .rd_i(rd), .wr_i(wr), .wdata_i(wd), .rdata_o(rdata), .rx_data_i(rx_byte),
    .line_status_i(line_st), .int_source_i(isrc), .tx_level_i(tx_lvl), .rx_level_i(rx_lvl),
    .resume_seen_i(1'b0), .pause_seen_i(pause), .tx_serial_i(txs), .cts_n_i(1'b0),
    .dsr_n_i(1'b0), .ri_n_i(1'b1), .cd_n_i(1'b1), .rx_serial_o(rxs), .tx_pin_o(txp),
    .rts_n_o(rts_n), .dtr_n_o(dtr_n), .holding_wr_o(hwr), .holding_rd_o(hrd),
    .transmit_holding_o(thold), .fifo_control_o(fctl), .baud_divisor_o(baud),
    .interrupt_enable_o(ien), .line_control_o(lctl), .modem_control_o(mctl),
    .feature_control_o(feat), .enhanced_function_o(efn), .tx_fifo_threshold_o(txth),
    .rx_fifo_threshold_o(rxth), .turnaround_delay_o(dly));
  task chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task w(input logic [3:0] a, input logic [7:0] d);
    ucrm_host_model_inst.access(1'b1, a, d, q);
  endtask
  task r(input logic [3:0] a);
    ucrm_host_model_inst.access(1'b0, a, 8'h00, q);
  endtask
  task final_report();
    if (failures == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task t_plain();
    w(4'h7, 8'ha5);
    r(4'h7); chk(q, 8'ha5);
    r(4'h5); chk(q, line_st);
    w(4'ha, 8'h33);
    r(4'ha); chk(q, tx_lvl);
    chk(txth, 8'h33);
    r(4'hb); chk(q, rx_lvl);
  endtask
  task t_div();
    w(4'h3, 8'h80);
    w(4'h0, 8'h12); chk(hwr, 1'b0);
    w(4'h1, 8'h34);
    r(4'h0); chk(q, 8'h12);
    r(4'h1); chk(q, 8'h34);
    w(4'h3, 8'h03); chk(lctl, 8'h03);
    w(4'h1, 8'hff);
    r(4'h1); chk(q, 8'h0f);
    chk(ien, 8'h0f);
    r(4'h0); chk(q, rx_byte);
    chk(hrd, 1'b1);
    chk(baud, 16'h3412);
    w(4'h0, 8'h77); chk(hwr, 1'b1);
    chk(thold, 8'h77);
  endtask
  task t_enh();
    w(4'h9, 8'h10);
    w(4'h1, 8'hff);
    r(4'h1); chk(q, 8'hef);
    w(4'h4, 8'h1f);
    repeat (5) @(posedge clk_i);
    chk({txp, rts_n, dtr_n, rxs}, 4'b1110);
    r(4'h6); chk(q & 8'hf0, 8'hf0);
    w(4'h9, 8'h00);
    w(4'h4, 8'hff);
    chk(mctl, 8'h1b);
    r(4'h2); chk(q, 8'h06);
    w(4'h4, 8'h03);
    chk({txp, rts_n, dtr_n, rxs}, 4'b0001);
  endtask
  task t_misc();
    w(4'h9, 8'h10); chk(efn, 8'h10);
    w(4'h2, 8'h31); chk(fctl, 8'h31);
    w(4'h6, 8'ha0); chk(dly, 4'ha);
    w(4'h8, 8'h5c); chk(feat, 8'h5c);
    w(4'hb, 8'h21); chk(rxth, 8'h21);
    @(posedge clk_i);
    #1 pause = 1'b1;
    @(posedge clk_i);
    #1 pause = 1'b0;
    r(4'h2); chk(q, 8'hd6);
    w(4'h9, 8'h00);
    r(4'h2); chk(q, 8'hc6);
    w(4'h2, 8'h31); chk(fctl, 8'h01);
    w(4'h6, 8'ha0); chk(dly, 4'h0);
  endtask
  task t_flags();
    w(4'hc, 8'h13);
    @(posedge clk_i);
    #1 pause = 1'b1;
    @(posedge clk_i);
    #1 pause = 1'b0;
    r(4'hc); chk(q, 8'h01);
    r(4'hc); chk(q, 8'h00);
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    #1 resetn_i = 1'b1;
    t_plain();
    t_div();
    t_enh();
    t_misc();
    t_flags();
    final_report();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    final_report();
  end
endmodule
bind ucrm_channel_regs ucrm_checker ucrm_checker_inst (.clk_i(clk_i), .resetn_i(resetn_i),
  .addr_i(addr_i), .wr_i(wr_i), .wdata_i(wdata_i), .tx_serial_i(tx_serial_i),
  .rx_serial_o(rx_serial_o), .tx_pin_o(tx_pin_o), .rts_n_o(rts_n_o), .dtr_n_o(dtr_n_o),
  .holding_wr_o(holding_wr_o), .transmit_holding_o(transmit_holding_o),
  .fifo_control_o(fifo_control_o), .turnaround_delay_o(turnaround_delay_o),
  .baud_divisor_o(baud_divisor_o), .interrupt_enable_o(interrupt_enable_o),
  .line_control_o(line_control_o), .modem_control_o(modem_control_o),
  .enhanced_function_o(enhanced_function_o));
